// File: pkg/vcpat_pkg.sv
// constants shared by the port arbitration table block
package vcpat_pkg;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int ADR_WIDTH = 12;
	localparam logic [ADR_WIDTH-1:0] ADDR_CONTROL = 12'h214; // vc_resource_control
	localparam logic [ADR_WIDTH-1:0] ADDR_STATUS = 12'h218; // vc_resource_status
	localparam logic [ADR_WIDTH-1:0] ADDR_TABLE0 = 12'h220; // arbitration_table_word_zero
	localparam int WORD_LSB = 2; // word index starts here
	// ****************************************
	// field positions
	// ****************************************
	localparam int LOAD_BIT = 16; // table_load_request in control
	localparam int COHERENCY_BIT = 16; // table_coherency_pending in status
	localparam int NEGOTIATION_BIT = 17; // channel_negotiation_pending in status
	localparam int SLOT_WIDTH = 4; // bits per phase slot
	localparam int SLOT_COUNT = 8; // slots in table word zero
	localparam int PHASE_WIDTH = 3; // phase index width
	localparam int BYTE_WIDTH = 8;
	localparam int LANE_COUNT = 4;
	// ****************************************
	// reset values and encodings
	// ****************************************
	localparam logic [31:0] TABLE0_RESET = 32'h1765_4321; // slot zero port 1 .. slot seven port 1
	localparam logic [31:0] REG_ZERO = 32'h0000_0000; // reserved bits and unmapped reads
	localparam logic [SLOT_WIDTH-1:0] PORT_LAST_VALID = 4'h7; // 8..15 reserved
	localparam logic [SLOT_WIDTH-1:0] UPSTREAM_PORT_ID = 4'h0; // port zero is upstream
	localparam logic [PHASE_WIDTH-1:0] PHASE_FIRST = 3'h0;
	localparam logic [PHASE_WIDTH-1:0] PHASE_LAST = 3'h7;
	localparam int PERIOD_CYCLES_DEFAULT = 4; // clocks per arbitration period
endpackage

// File: hdl/vcpat_slot_walker.sv
// walks the loaded phase slots and names the winning ingress port
`timescale 1ns/1ps
module vcpat_slot_walker #(
	parameter logic [vcpat_pkg::SLOT_WIDTH-1:0] EGRESS_PORT = 4'h0
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [31:0] slotTable,
	input wire logic periodTick,
	output logic [vcpat_pkg::SLOT_WIDTH-1:0] grantPort,
	output logic grantValid,
	output logic [vcpat_pkg::PHASE_WIDTH-1:0] grantPhase
);
	import vcpat_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [PHASE_WIDTH-1:0] phase; // slot being visited
		logic [SLOT_WIDTH-1:0] port; // granted port
		logic valid; // grant is live
	} vcpat_walk_state_t;

	vcpat_walk_state_t s; // current state
	vcpat_walk_state_t next_s; // next state
	logic [SLOT_WIDTH-1:0] curSlot; // port id in current slot
	logic curUsable; // current slot names a legal port

	// true for ports 0..7 other than the egress port
	function automatic logic slotUsable(input logic [SLOT_WIDTH-1:0] id);
		slotUsable = (id <= PORT_LAST_VALID) && (id != EGRESS_PORT);
	endfunction

	// refuse an egress id outside the port range
	if (EGRESS_PORT > PORT_LAST_VALID) begin : g_bad_egress
		$error("egress port id out of range");
	end

	assign curSlot = slotTable[s.phase*SLOT_WIDTH +: SLOT_WIDTH];
	assign curUsable = slotUsable(curSlot);

	// next phase and grant
	always_comb begin
		next_s = s;
		next_s.port = curSlot;
		next_s.valid = curUsable;
		if (!curUsable || periodTick) begin
			next_s.phase = (s.phase == PHASE_LAST) ? PHASE_FIRST : s.phase + 1'b1;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign grantPort = s.port;
	assign grantValid = s.valid;
	assign grantPhase = s.phase;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	a_skip_invalid: assert property (!curUsable |=> s.phase == $past(s.phase) + 1'b1)
		else $error("invalid slot not skipped at once");
	a_grant_legal: assert property (grantValid |-> grantPort <= PORT_LAST_VALID && grantPort != EGRESS_PORT)
		else $error("grant names reserved or egress port");
	a_phase_wrap: assert property (s.phase == PHASE_LAST && (periodTick || !curUsable) |=> s.phase == PHASE_FIRST)
		else $error("phase did not wrap to zero");
	a_phase_hold: assert property (curUsable && !periodTick |=> $stable(s.phase))
		else $error("phase moved inside a period");
endmodule // vcpat_slot_walker

// File: hdl/vcpat_table_regs.sv
// status, control and table word zero of the single vc resource, with slot walker
//
// What this block does
// - table write sets coherency flag until loaded
// - coherency flag reads zero on downstream ports
// - negotiation flag shows flow control init pending
// - slot ids 0-7 are ports, 8-15 reserved
// - invalid slot skipped with no delay
// - word zero holds eight 4-bit slots
// - load request reads zero, writing zero ignored
// - load request acts only on upstream port
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module vcpat_table_regs #(
	parameter bit UPSTREAM = 1'b1,
	parameter logic [vcpat_pkg::SLOT_WIDTH-1:0] EGRESS_PORT = 4'h0,
	parameter int PERIOD_CYCLES = vcpat_pkg::PERIOD_CYCLES_DEFAULT
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [vcpat_pkg::ADR_WIDTH-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic fcInitPending,
	output logic [vcpat_pkg::SLOT_WIDTH-1:0] grantPort,
	output logic grantValid,
	output logic [vcpat_pkg::PHASE_WIDTH-1:0] grantPhase
);
	import vcpat_pkg::*;

	// ****************************************
	// behaviour notes
	// ****************************************
	// every bus cycle is answered one clock after it is taken
	// ack is a single pulse even if the strobe is held high
	// read data is zero whenever ack is low
	// unmapped addresses answer with zero, writes to them are dropped
	// table writes go to the software copy only
	// the walker sees the active copy, changed by a load alone
	// a load finishes one clock after the accepted control write
	// a table write in that same clock keeps the flag set
	// the period divider runs free, so the first period after
	// a load or a skip may be shorter than the full count
	// downstream ends keep the table writable but never load it
	// reserved and egress ids in a slot are skipped, never granted
	// the negotiation bit is a live view of flow control init
	// the control register keeps no state; its load bit reads zero
	// grant outputs lag the phase index by one clock

	localparam int DIV_WIDTH = $clog2(PERIOD_CYCLES + 1);
	localparam logic [DIV_WIDTH-1:0] DIV_LAST = DIV_WIDTH'(PERIOD_CYCLES - 1);

	// refuse a period the divider cannot count
	if (PERIOD_CYCLES < 1) begin : g_bad_period
		$error("period must be at least one cycle");
	end

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic ack; // bus answer
		logic [31:0] rdata; // registered read data
		logic [31:0] table0; // software copy of word zero
		logic [31:0] active; // copy in use by the walker
		logic coherencyPending; // table written, not yet loaded
		logic loadPending; // load accepted, copy next cycle
		logic [DIV_WIDTH-1:0] divCount; // period divider
	} vcpat_reg_state_t;

	vcpat_reg_state_t s; // current state
	vcpat_reg_state_t next_s; // next state
	logic request; // new bus cycle seen
	logic tableWrite; // write hits table word zero
	logic loadWrite; // one written to load request
	logic readStatus; // read of status
	logic readControl; // read of control
	logic readTable; // read of table word zero
	logic periodTick; // one pulse per arbitration period

	// word address match
	function automatic logic hits(input logic [ADR_WIDTH-1:0] adr, input logic [ADR_WIDTH-1:0] reg_adr);
		hits = adr[ADR_WIDTH-1:WORD_LSB] == reg_adr[ADR_WIDTH-1:WORD_LSB];
	endfunction

	// ****************************************
	// bus decode
	// ****************************************
	// a new cycle is taken only while ack is low
	assign request = wb_cyc_i && wb_stb_i && !s.ack;
	assign tableWrite = request && wb_we_i && hits(wb_adr_i, ADDR_TABLE0) && (|wb_sel_i);
	assign loadWrite = request && wb_we_i && hits(wb_adr_i, ADDR_CONTROL) && wb_sel_i[LOAD_BIT/BYTE_WIDTH]
		&& wb_dat_i[LOAD_BIT];
	assign readStatus = request && !wb_we_i && hits(wb_adr_i, ADDR_STATUS);
	assign readControl = request && !wb_we_i && hits(wb_adr_i, ADDR_CONTROL);
	assign readTable = request && !wb_we_i && hits(wb_adr_i, ADDR_TABLE0);
	assign periodTick = (s.divCount == DIV_LAST);

	// next state of registers, load and divider
	always_comb begin
		next_s = s;
		// one-cycle ack, every address answered
		next_s.ack = request;
		// period divider
		next_s.divCount = periodTick ? '0 : s.divCount + 1'b1;
		if (tableWrite) begin
			for (int lane = 0; lane < LANE_COUNT; lane++) begin
				if (wb_sel_i[lane]) begin
					next_s.table0[lane*BYTE_WIDTH +: BYTE_WIDTH] = wb_dat_i[lane*BYTE_WIDTH +: BYTE_WIDTH];
				end
			end
		end
		if (loadWrite && UPSTREAM) begin
			next_s.loadPending = 1'b1;
		end
		// finish the load by copying the table
		// the copy uses the table as it stood before this clock
		if (s.loadPending) begin
			next_s.active = s.table0;
			next_s.loadPending = 1'b0;
		end
		next_s.coherencyPending = (s.coherencyPending && !s.loadPending) || tableWrite;
		if (!UPSTREAM) begin
			next_s.coherencyPending = 1'b0;
		end
		// read data, reserved bits zero
		next_s.rdata = REG_ZERO;
		if (readStatus) begin
			next_s.rdata[COHERENCY_BIT] = s.coherencyPending;
			next_s.rdata[NEGOTIATION_BIT] = fcInitPending;
		end else if (readTable) begin
			next_s.rdata = s.table0;
		end else if (readControl) begin
			next_s.rdata = REG_ZERO;
		end
	end

	// state register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '{ack: 1'b0, rdata: REG_ZERO, table0: TABLE0_RESET, active: TABLE0_RESET,
				coherencyPending: 1'b0, loadPending: 1'b0, divCount: '0};
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdata;

	// ****************************************
	// arbitration walk
	// ****************************************
	vcpat_slot_walker #(
		.EGRESS_PORT(EGRESS_PORT)
	) u_walker (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.slotTable(s.active),
		.periodTick(periodTick),
		.grantPort(grantPort),
		.grantValid(grantValid),
		.grantPhase(grantPhase)
	);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence sTableWrite;
		UPSTREAM && tableWrite;
	endsequence

	// load finishing with no table write beside it
	sequence sLoadFinish;
		s.loadPending && !tableWrite;
	endsequence

	a_flag_on_write: assert property (sTableWrite |=> s.coherencyPending)
		else $error("table write did not set coherency flag");
	a_flag_until_load: assert property (s.coherencyPending && !s.loadPending |=> s.coherencyPending)
		else $error("coherency flag cleared without load");
	a_flag_load_clears: assert property (sLoadFinish |=> !s.coherencyPending)
		else $error("load did not clear coherency flag");
	a_load_copies: assert property (s.loadPending |=> s.active == $past(s.table0))
		else $error("load did not copy table");
	a_downstream_zero: assert property (!UPSTREAM |-> !s.coherencyPending)
		else $error("coherency flag set on downstream port");
	a_neg_status: assert property (readStatus |=> wb_dat_o[NEGOTIATION_BIT] == $past(fcInitPending))
		else $error("negotiation bit does not follow flow control init");
	a_load_reads_zero: assert property (readControl |=> wb_ack_o && wb_dat_o == REG_ZERO)
		else $error("control read not zero");
	a_load_ignored: assert property (!UPSTREAM && loadWrite |=> !s.loadPending)
		else $error("downstream load accepted");
	a_table_readback: assert property (readTable |=> wb_dat_o == $past(s.table0))
		else $error("table read mismatch");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");

	// bus data, full word write and downstream load checks
	a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == REG_ZERO)
		else $error("read data not zero outside ack");
	a_flag_readback: assert property (readStatus |=> wb_dat_o[COHERENCY_BIT] == $past(s.coherencyPending))
		else $error("coherency bit does not follow flag");
	a_word_write: assert property (tableWrite && wb_sel_i == 4'hF |=> s.table0 == $past(wb_dat_i))
		else $error("full word table write lost");
	a_down_no_load: assert property (!UPSTREAM |-> s.active == TABLE0_RESET)
		else $error("downstream active copy changed");
endmodule // vcpat_table_regs

// File: testbench/tb_vcpat_table_regs.sv
// self-checking bench for the port arbitration table registers and slot walker
`timescale 1ns/1ps
module tb_vcpat_table_regs;
	import vcpat_pkg::*;
	// ****************************************
	// settings, clock and signals
	// ****************************************
	localparam logic [SLOT_WIDTH-1:0] EGRESS = 4'h2; // egress id used by both ends
	localparam int PERIOD = 3; // short arbitration period
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, weI = 1'b0, fcInitPending = 1'b0;
	logic [ADR_WIDTH-1:0] adr = '0;
	logic [3:0] sel = 4'h0;
	logic [31:0] datI = 32'h0000_0000, datO, datDown, rd, rdDown;
	logic ackO, ackDown, grantValid;
	logic [SLOT_WIDTH-1:0] grantPort;
	logic [PHASE_WIDTH-1:0] grantPhase;
	int errCount = 0, nTests = 0, cycles = 0;
	// 25 MHz clock
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// upstream end under test
	vcpat_table_regs #(.UPSTREAM(1'b1), .EGRESS_PORT(EGRESS), .PERIOD_CYCLES(PERIOD)) u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(weI),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ackO),
		.fcInitPending(fcInitPending), .grantPort(grantPort), .grantValid(grantValid), .grantPhase(grantPhase));
	// downstream end sharing the same bus requests
	vcpat_table_regs #(.UPSTREAM(1'b0), .EGRESS_PORT(EGRESS), .PERIOD_CYCLES(PERIOD)) u_down (
		.clk_sys(clk_sys), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(weI),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datDown), .wb_ack_o(ackDown),
		.fcInitPending(fcInitPending), .grantPort(), .grantValid(), .grantPhase());
	// ****************************************
	// shared tasks
	// ****************************************
	// compare and count
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errCount++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// verdict and end of run
	task complete_run();
		$display("checks %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one classic cycle, entered just after a rising edge
	task wb(input logic we, input logic [ADR_WIDTH-1:0] a, input logic [31:0] d);
		cyc <= 1'b1; stb <= 1'b1; weI <= we; adr <= a; sel <= 4'hF; datI <= d;
		// wait for ack; if none comes, only the hang guard ends this wait
		do begin
			@(posedge clk_sys);
		end while (ackO !== 1'b1);
		rd = datO;
		rdDown = datDown;
		cyc <= 1'b0; stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	// follow the walker for a while and check order, lag and dwell
	task walk_check(input logic [31:0] tbl);
		int run;
		bit first, legal;
		logic [PHASE_WIDTH-1:0] ph, nxt;
		logic [SLOT_WIDTH-1:0] id;
		run = 1; first = 1;
		#1;
		ph = grantPhase;
		repeat (60) begin
			id = tbl[ph*4 +: 4];
			legal = (id <= PORT_LAST_VALID) && (id != EGRESS);
			nxt = ph + 3'h1;
			@(posedge clk_sys);
			#1;
			check("grantValid", grantValid, legal);
			if (legal) check("grantPort", grantPort, id);
			if (grantPhase === ph) run++;
			else begin
				check("grantPhase", grantPhase, nxt);
				if (!first) check("dwell", run, legal ? PERIOD : 1);
				first = 0; run = 1; ph = grantPhase;
			end
		end
		@(posedge clk_sys);
	endtask
	// ****************************************
	// timeout and main sequence
	// ****************************************
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles >= 5000) begin
			errCount++;
			complete_run();
		end
	end
	// tests
	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		wb(1'b0, ADDR_STATUS, 0); check("status", rd, REG_ZERO);
		wb(1'b0, ADDR_TABLE0, 0); check("table", rd, TABLE0_RESET);
		wb(1'b0, ADDR_CONTROL, 0); check("control", rd, REG_ZERO);
		$display("test reset values done");
		fcInitPending <= 1'b1;
		wb(1'b0, ADDR_STATUS, 0); check("negotiation", rd, 32'h0002_0000);
		check("negotiation down", rdDown, 32'h0002_0000);
		fcInitPending <= 1'b0;
		wb(1'b0, ADDR_STATUS, 0); check("negotiation off", rd, REG_ZERO);
		$display("test negotiation done");
		wb(1'b1, ADDR_TABLE0, 32'h7654_2F83);
		wb(1'b0, ADDR_TABLE0, 0); check("table rw", rd, 32'h7654_2F83);
		wb(1'b0, ADDR_STATUS, 0); check("coherency set", rd, 32'h0001_0000);
		check("coherency down", rdDown, REG_ZERO);
		wb(1'b1, ADDR_CONTROL, REG_ZERO);
		wb(1'b0, ADDR_STATUS, 0); check("zero load", rd, 32'h0001_0000);
		wb(1'b1, ADDR_CONTROL, 32'h0001_0000);
		wb(1'b0, ADDR_CONTROL, 0); check("load readback", rd, REG_ZERO);
		wb(1'b0, ADDR_STATUS, 0); check("coherency clear", rd, REG_ZERO);
		check("down after load", rdDown, REG_ZERO);
		$display("test coherency and load done");
		walk_check(32'h7654_2F83);
		$display("test slot walk done");
		wb(1'b1, ADDR_TABLE0, 32'h7165_4301);
		wb(1'b1, ADDR_CONTROL, 32'h0001_0000);
		wb(1'b0, ADDR_STATUS, 0); check("reload clear", rd, REG_ZERO);
		walk_check(32'h7165_4301);
		$display("test legal table walk done");
		wb(1'b1, 12'h300, 32'hDEAD_BEEF);
		wb(1'b0, 12'h300, 0); check("unmapped", rd, REG_ZERO);
		$display("test unmapped done");
		complete_run();
	end
endmodule // tb_vcpat_table_regs
